/* File: uhrf_pkg.sv */
// Shared constants for the serial port register front end
package uhrf_pkg;

  // ************************************************************
  // Widths and depths
  // ************************************************************
  localparam int DATA_W     = 8;
  localparam int ADR_W      = 8;
  localparam int WB_DW      = 32;
  localparam int SEL_W      = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int LVL_W      = 5;
  localparam int DIV_W      = 16;
  localparam int OVS_W      = 4;
  localparam int IID_W      = 4;
  localparam int STAT_W     = 5;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [ADR_W-1:0] OFF_DATA  = 8'h00;
  localparam logic [ADR_W-1:0] OFF_IER   = 8'h04;
  localparam logic [ADR_W-1:0] OFF_IID   = 8'h08;
  localparam logic [ADR_W-1:0] OFF_ISTAT = 8'h40;

  // ************************************************************
  // Reset values and field layout
  // ************************************************************
  localparam logic [DATA_W-1:0] RX_BUF_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IER_RST     = 8'h00;
  localparam logic [DATA_W-1:0] IER_WR_MASK = 8'h8f;
  localparam logic [DIV_W-1:0]  DIV_RST     = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST    = 5'h00;
  localparam logic [WB_DW-1:0]  WB_ZERO     = 32'h0000_0000;

  localparam int IE_RX   = 0;
  localparam int IE_TX   = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MDM  = 3;
  localparam int IE_TMO  = 4;
  localparam int IE_PROG = 7;
  localparam int DIV_HI  = 8;

  localparam logic [1:0] FIFO_ON_CODE  = 2'h3;
  localparam logic [1:0] FIFO_OFF_CODE = 2'h0;
  localparam logic [1:0] IID_PAD       = 2'h0;
  localparam logic [2:0] ISTAT_PAD     = 3'h0;

  // ************************************************************
  // Interrupt identity codes
  // ************************************************************
  localparam logic [IID_W-1:0] IID_NONE = 4'h1;
  localparam logic [IID_W-1:0] IID_LINE = 4'h6;
  localparam logic [IID_W-1:0] IID_RXD  = 4'h4;
  localparam logic [IID_W-1:0] IID_TMO  = 4'hc;
  localparam logic [IID_W-1:0] IID_TXE  = 4'h2;
  localparam logic [IID_W-1:0] IID_MDM  = 4'h0;

  // ************************************************************
  // Fifo levels and divider values
  // ************************************************************
  localparam logic [LVL_W-1:0] LVL_EMPTY    = 5'h00;
  localparam logic [LVL_W-1:0] LVL_ONE      = 5'h01;
  localparam logic [LVL_W-1:0] LVL_FULL     = 5'h10;
  localparam logic [LVL_W-1:0] TX_PROG_LVL  = 5'h04;
  localparam logic [LVL_W-1:0] TX_PROG_HIT  = 5'h05;
  localparam logic [PTR_W-1:0] PTR_RST      = 4'h0;
  localparam logic [PTR_W-1:0] PTR_STEP     = 4'h1;
  localparam logic [DIV_W-1:0] DIV_ONE      = 16'h0001;
  localparam logic [OVS_W-1:0] OVS_LAST     = 4'hf;
  localparam logic [OVS_W-1:0] OVS_RST      = 4'h0;
  localparam logic [OVS_W-1:0] OVS_STEP     = 4'h1;

endpackage

/* File: uhrf_fifo_if.sv */
// Carrier between the front end and its byte fifos
`timescale 1ns/10ps
`default_nettype none
interface uhrf_fifo_if
  import uhrf_pkg::*;
();
  logic              push;
  logic [DATA_W-1:0] wr_data;
  logic              pop;
  logic              full;
  logic              empty;
  logic [DATA_W-1:0] rd_data;
  logic [LVL_W-1:0]  level;

  modport user  (output push, wr_data, pop, input full, empty, rd_data, level);
  modport store (input push, wr_data, pop, output full, empty, rd_data, level);
endinterface
`default_nettype wire

/* File: uhrf_fifo.sv */
// Sixteen byte fifo whose head byte sits in a register
`timescale 1ns/10ps
`default_nettype none
module uhrf_fifo
  import uhrf_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  uhrf_fifo_if.store  f
);

  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0]  wr_ptr_q;
  logic [PTR_W-1:0]  rd_ptr_q;
  logic [LVL_W-1:0]  lvl_q;
  logic [DATA_W-1:0] head_q;

  wire              full_w  = (lvl_q == LVL_FULL);
  wire              empty_w = (lvl_q == LVL_EMPTY);
  // A push on a full fifo is refused here, so queued bytes are never lost
  wire              do_push = f.push & ~full_w;
  wire              do_pop  = f.pop & ~empty_w;
  wire [PTR_W-1:0]  rd_next = do_pop ? rd_ptr_q + PTR_STEP : rd_ptr_q;
  // Bypass keeps the head register right when a byte lands in an empty fifo
  wire              bypass  = do_push & (wr_ptr_q == rd_next);

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= PTR_RST;
      rd_ptr_q <= PTR_RST;
      lvl_q    <= LVL_EMPTY;
      head_q   <= RX_BUF_RST;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + PTR_STEP;
      end
      rd_ptr_q <= rd_next;
      if (do_push & ~do_pop) begin
        lvl_q <= lvl_q + LVL_ONE;
      end else if (do_pop & ~do_push) begin
        lvl_q <= lvl_q - LVL_ONE;
      end
      head_q <= bypass ? f.wr_data : mem_q[rd_next];
    end
  end

  assign f.full    = full_w;
  assign f.empty   = empty_w;
  assign f.rd_data = head_q;
  assign f.level   = lvl_q;

endmodule
`default_nettype wire

/* File: uhrf_baud.sv */
// Baud divider: oversample tick and bit tick from the divisor
`timescale 1ns/10ps
`default_nettype none
module uhrf_baud
  import uhrf_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  sample_tick_o,
  output logic                  bit_tick_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [OVS_W-1:0] ovs_q;

  // A zero divisor stops both ticks rather than running at clock rate
  wire div_on = (div_i != DIV_RST);
  wire wrap   = div_on & (cnt_q >= div_i - DIV_ONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q         <= DIV_RST;
      ovs_q         <= OVS_RST;
      sample_tick_o <= 1'b0;
      bit_tick_o    <= 1'b0;
    end else begin
      cnt_q         <= wrap | ~div_on ? DIV_RST : cnt_q + DIV_ONE;
      sample_tick_o <= wrap;
      if (wrap) begin
        ovs_q <= ovs_q + OVS_STEP;
      end
      bit_tick_o <= wrap & (ovs_q == OVS_LAST);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_tick_div_one;
    (div_i == DIV_ONE) && $stable(div_i) && sample_tick_o |=> sample_tick_o;
  endproperty
  a_tick_div_one: assert property (p_tick_div_one) else $error("divisor one tick gap");

  property p_no_tick_zero;
    (div_i == DIV_RST) ##1 (div_i == DIV_RST) |=> !sample_tick_o && !bit_tick_o;
  endproperty
  a_no_tick_zero: assert property (p_no_tick_zero) else $error("tick with zero divisor");

endmodule
`default_nettype wire

/* File: uhrf_front.sv */
// Serial port register front end: fifos, divisor and interrupt enables
//
// Overview of operation
// - With divisor select low, reading offset 0x00 pops the oldest received byte.
// - Full receive fifo keeps its bytes and drops further incoming bytes.
// - With divisor select low, writing offset 0x00 queues a byte, sixteen deep.
// - Writing while the transmit fifo is full is dropped, queue untouched.
// - With divisor select high, offsets 0x00/0x04 are divisor low/high bytes.
// - Bit rate is clock divided by sixteen times the divisor.
// - With divisor select low, offset 0x04 holds five interrupt enables.
// - Enable bits 3,2,1,0 gate modem, line, transmit empty, receive data.
// - Enable bit 7 acts only with fifo mode and bit 1 set.
// - Under automatic clear-to-send control with fifo mode on, its changes raise no modem interrupt.
// - Receive buffer and enables reset to zero; divisor select picks the view.
// - Identity codes 0001,0110,0100,1100,0010,0000 by falling priority.
`timescale 1ns/10ps
`default_nettype none
module uhrf_front
  import uhrf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [WB_DW-1:0]  wb_dat_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  output logic      [WB_DW-1:0]  wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              divisor_access_select_i,
  input  wire logic              fifo_enable_i,
  input  wire logic              auto_cts_en_i,
  input  wire logic              cts_change_i,
  input  wire logic              line_status_evt_i,
  input  wire logic              char_timeout_evt_i,
  input  wire logic              rx_valid_i,
  input  wire logic [DATA_W-1:0] rx_data_i,
  input  wire logic              tx_ready_i,
  output logic                   tx_valid_o,
  output logic      [DATA_W-1:0] tx_data_o,
  output logic                   sample_tick_o,
  output logic                   bit_tick_o,
  output logic                   data_ready_o,
  output logic                   irq_o
);

  // ************************************************************
  // Storage
  // ************************************************************
  uhrf_fifo_if rx_if ();
  uhrf_fifo_if tx_if ();

  uhrf_fifo u_rx_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .f     (rx_if.store)
  );

  uhrf_fifo u_tx_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .f     (tx_if.store)
  );

  logic [DIV_W-1:0]  div_q;
  logic [DATA_W-1:0] ier_q;
  logic [STAT_W-1:0] stat_q;
  logic              ack_q;
  logic [WB_DW-1:0]  dat_q;
  logic              irq_q;
  logic              dr_q;
  logic              tx_valid_q;
  logic [DATA_W-1:0] tx_data_q;

  uhrf_baud u_baud (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .div_i         (div_q),
    .sample_tick_o (sample_tick_o),
    .bit_tick_o    (bit_tick_o)
  );

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Every access is answered one cycle later, unmapped ones with zero data
  wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire rd       = req & ~wb_we_i;
  wire divisor_access_select     = divisor_access_select_i;
  wire hit_data = (wb_adr_i == OFF_DATA);
  wire hit_ier  = (wb_adr_i == OFF_IER);
  wire hit_iid  = (wb_adr_i == OFF_IID);
  wire hit_stat = (wb_adr_i == OFF_ISTAT);

  wire rx_rd_hit = rd & hit_data & ~divisor_access_select;
  wire tx_wr_hit = wr & hit_data & ~divisor_access_select;
  wire div_lo_we = wr & hit_data & divisor_access_select;
  wire div_hi_we = wr & hit_ier & divisor_access_select;
  wire ier_we    = wr & hit_ier & ~divisor_access_select;
  wire stat_clr  = rd & hit_stat;

  // ************************************************************
  // Byte paths
  // ************************************************************
  assign rx_if.push    = rx_valid_i;
  assign rx_if.wr_data = rx_data_i;
  assign rx_if.pop     = rx_rd_hit & ~rx_if.empty;

  // Bytes beyond sixteen are refused inside the fifo
  assign tx_if.push    = tx_wr_hit;
  assign tx_if.wr_data = wb_dat_i[DATA_W-1:0];

  // One output stage decouples the transmitter handshake from the fifo
  wire tx_load         = ~tx_if.empty & (~tx_valid_q | tx_ready_i);
  assign tx_if.pop     = tx_load;
  wire tx_valid_d      = tx_load | (tx_valid_q & ~tx_ready_i);

  // ************************************************************
  // Interrupt events and identity
  // ************************************************************
  wire prog_eff  = ier_q[IE_PROG] & ier_q[IE_TX] & fifo_enable_i;
  wire tx_level_hit = prog_eff ? (tx_if.level == TX_PROG_HIT) : (tx_if.level == LVL_ONE);
  wire tx_evt    = tx_if.pop & ~tx_if.push & tx_level_hit;
  wire auto_cts  = auto_cts_en_i & fifo_enable_i;
  wire mdm_evt   = cts_change_i & ~auto_cts;
  wire rx_evt    = rx_valid_i & ~rx_if.full;

  wire [STAT_W-1:0] evt_vec;
  assign evt_vec[IE_RX]   = rx_evt;
  assign evt_vec[IE_TX]   = tx_evt;
  assign evt_vec[IE_LINE] = line_status_evt_i;
  assign evt_vec[IE_MDM]  = mdm_evt;
  assign evt_vec[IE_TMO]  = char_timeout_evt_i;

  // Character timeout shares the receive data enable
  wire [STAT_W-1:0] mask_vec = {ier_q[IE_RX], ier_q[IE_MDM:IE_RX]};
  wire [STAT_W-1:0] pend     = stat_q & mask_vec;
  // A new event in the clearing read's cycle survives the clear
  wire [STAT_W-1:0] stat_d   = (stat_clr ? STAT_RST : stat_q) | evt_vec;

  wire [IID_W-1:0] interrupt_id_code =
    pend[IE_LINE] ? IID_LINE :
    pend[IE_RX]   ? IID_RXD  :
    pend[IE_TMO]  ? IID_TMO  :
    pend[IE_TX]   ? IID_TXE  :
    pend[IE_MDM]  ? IID_MDM  : IID_NONE;

  // ************************************************************
  // Read data
  // ************************************************************
  wire [DATA_W-1:0] data_view = divisor_access_select ? div_q[DATA_W-1:0] : rx_if.rd_data;
  wire [DATA_W-1:0] ier_view  = divisor_access_select ? div_q[DIV_W-1:DIV_HI] : ier_q;
  wire [DATA_W-1:0] iid_view  = {fifo_enable_i ? FIFO_ON_CODE : FIFO_OFF_CODE, IID_PAD, interrupt_id_code};
  wire [DATA_W-1:0] stat_view = {ISTAT_PAD, stat_q};
  wire [DATA_W-1:0] rd_byte   =
    hit_data ? data_view :
    hit_ier  ? ier_view  :
    hit_iid  ? iid_view  :
    hit_stat ? stat_view : RX_BUF_RST;
  wire [WB_DW-1:0] rd_word = {WB_ZERO[WB_DW-1:DATA_W], rd_byte};

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= WB_ZERO;
    end else begin
      ack_q <= req;
      if (rd) begin
        dat_q <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= DIV_RST;
      ier_q <= IER_RST;
    end else begin
      if (div_lo_we) begin
        div_q[DATA_W-1:0] <= wb_dat_i[DATA_W-1:0];
      end
      if (div_hi_we) begin
        div_q[DIV_W-1:DIV_HI] <= wb_dat_i[DATA_W-1:0];
      end
      if (ier_we) begin
        ier_q <= wb_dat_i[DATA_W-1:0] & IER_WR_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= STAT_RST;
      irq_q  <= 1'b0;
      dr_q   <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |pend;
      dr_q   <= ~rx_if.empty;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= RX_BUF_RST;
    end else begin
      tx_valid_q <= tx_valid_d;
      if (tx_load) begin
        tx_data_q <= tx_if.rd_data;
      end
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign irq_o        = irq_q;
  assign data_ready_o = dr_q;
  assign tx_valid_o   = tx_valid_q;
  assign tx_data_o    = tx_data_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_bus_answer;
    s_req |=> s_ack_once;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

  property p_rx_pop;
    rx_rd_hit && !rx_if.empty && !rx_valid_i |=> rx_if.level == $past(rx_if.level) - LVL_ONE;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive read did not remove byte");

  property p_rx_drop;
    rx_valid_i && rx_if.full |=> rx_if.level <= $past(rx_if.level);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("full receive fifo grew");

  property p_tx_push;
    tx_wr_hit && !tx_if.full && !tx_if.pop |=> tx_if.level == $past(tx_if.level) + LVL_ONE;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("transmit write not queued");

  property p_tx_drop;
    tx_wr_hit && tx_if.full |=> tx_if.level <= $past(tx_if.level);
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("full transmit fifo grew");

  property p_div_lo;
    div_lo_we |=> div_q[DATA_W-1:0] == $past(wb_dat_i[DATA_W-1:0]);
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("divisor low byte not written");

  property p_ier_rsvd;
    ier_q[IE_PROG-1:IE_TMO] == ISTAT_PAD;
  endproperty
  a_ier_rsvd: assert property (p_ier_rsvd) else $error("reserved enable bits set");

  property p_auto_cts;
    cts_change_i && auto_cts && !stat_q[IE_MDM] |=> !stat_q[IE_MDM];
  endproperty
  a_auto_cts: assert property (p_auto_cts) else $error("modem event under auto cts");

  property p_irq_level;
    (|pend) |=> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("enabled event did not interrupt");

  property p_iid_none;
    !(|pend) |-> interrupt_id_code == IID_NONE;
  endproperty
  a_iid_none: assert property (p_iid_none) else $error("identity not idle code");

  property p_iid_line;
    pend[IE_LINE] |-> interrupt_id_code == IID_LINE;
  endproperty
  a_iid_line: assert property (p_iid_line) else $error("line status not top priority");

  property p_prog_off;
    !fifo_enable_i && tx_evt |-> tx_if.level == LVL_ONE;
  endproperty
  a_prog_off: assert property (p_prog_off) else $error("programmable level used outside fifo mode");

endmodule
`default_nettype wire

/* File: uhrf_peer.sv */
// Behavioural serial peripheral on the far side of the byte streams
`timescale 1ns/10ps
`default_nettype none
module uhrf_peer
  import uhrf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              tx_valid_i,
  input  wire logic [DATA_W-1:0] tx_data_i,
  output logic                   tx_ready_o,
  output logic                   rx_valid_o,
  output logic      [DATA_W-1:0] rx_data_o
);
  int                budget;
  logic [DATA_W-1:0] got[$];

  initial begin
    budget = 0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5a;
  end

  // ************************************************************
  // Transmit side: a zero budget stalls the front end
  // ************************************************************
  assign tx_ready_o = (budget > 0);

  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
      budget <= budget - 1;
    end
  end

  // ************************************************************
  // Receive side
  // ************************************************************
  // Outside a strobe the data lines show the inverse, never a stale copy
  task automatic send(input logic [DATA_W-1:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o  <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the serial port register front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, sn); end end
module testbench
  import uhrf_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, divisor_access_select, fifo_en, auto_cts;
  logic tx_ready, tx_valid, rx_valid, stick, btick, dready, irq;
  logic [ADR_W-1:0]  adr;
  logic [WB_DW-1:0]  wdat, rdat, r;
  logic [SEL_W-1:0]  sel;
  logic [2:0]        ev;
  logic [DATA_W-1:0] rx_data, tx_data;
  int                miscompares, checks_done;

  uhrf_front dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .divisor_access_select_i(divisor_access_select), .fifo_enable_i(fifo_en),
    .auto_cts_en_i(auto_cts), .cts_change_i(ev[2]), .line_status_evt_i(ev[0]),
    .char_timeout_evt_i(ev[1]), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .sample_tick_o(stick), .bit_tick_o(btick), .data_ready_o(dready), .irq_o(irq));

  uhrf_peer peer (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ************************************************************
  // Bus and helper tasks
  // ************************************************************
  task automatic stop_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [SEL_W-1:0] s);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    sel  <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    wb(1'b0, a, 8'h00, 4'h1);
    `CHK(nm, {24'h000000, ex}, r)
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    ev <= 3'h1 << k;
    @(posedge clk_i);
    ev <= 3'h0;
  endtask

  task automatic wait_got(input int n);
    int c;
    c = 0;
    while (peer.got.size() < n && c < 200) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= 200) begin
      miscompares++;
      stop_test();
    end
    repeat (3) @(posedge clk_i);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    int n;
    int s;
    rdchk(OFF_DATA, 8'h00, "rx_buf");
    rdchk(OFF_IER, 8'h00, "ier");
    rdchk(OFF_IID, 8'h01, "iid");
    wr(OFF_IER, 8'hff);
    rdchk(OFF_IER, 8'h8f, "ier");
    wb(1'b1, OFF_IER, 8'h00, 4'h0);
    rdchk(OFF_IER, 8'h8f, "ier");
    rdchk(8'h0c, 8'h00, "unmapped");
    divisor_access_select <= 1'b1;
    wr(OFF_DATA, 8'h02);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (btick !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      stop_test();
    end
    n = 0;
    s = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (stick === 1'b1) s++;
    end while (btick !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      stop_test();
    end
    `CHK("bit_period", 32, n)
    `CHK("sample_ticks", 16, s)
    // Divisor one must tick on every clock
    wr(OFF_DATA, 8'h01);
    repeat (4) begin
      @(posedge clk_i);
      `CHK("tick_div_one", 1'b1, stick)
    end
    wr(OFF_IER, 8'h12);
    wr(OFF_DATA, 8'h34);
    rdchk(OFF_DATA, 8'h34, "div_low");
    rdchk(OFF_IER, 8'h12, "div_high");
    divisor_access_select <= 1'b0;
    rdchk(OFF_IER, 8'h8f, "ier");
    wr(OFF_IER, 8'h00);
  endtask

  task automatic t_rx();
    for (int i = 0; i < 17; i++) peer.send(8'h30 + i[7:0]);
    for (int i = 0; i < 16; i++) begin
      `CHK("data_ready", 1'b1, dready)
      rdchk(OFF_DATA, 8'h30 + i[7:0], "rx_byte");
    end
    repeat (2) @(posedge clk_i);
    `CHK("data_ready", 1'b0, dready)
  endtask

  task automatic t_tx();
    peer.got.delete();
    // One byte sits in the output stage, sixteen fill the fifo, the last is lost
    for (int i = 0; i < 18; i++) wr(OFF_DATA, 8'ha0 + i[7:0]);
    peer.budget <= 100;
    wait_got(17);
    `CHK("tx_count", 17, peer.got.size())
    for (int i = 0; i < 17; i++) `CHK("tx_byte", 8'ha0 + i[7:0], peer.got[i])
    peer.budget <= 0;
  endtask

  task automatic t_irq();
    int          k[6] = '{0, 0, 1, 2, 2, 2};
    logic [7:0]  ie[6] = '{8'h04, 8'h00, 8'h01, 8'h08, 8'h07, 8'h08};
    logic [7:0]  id[6] = '{8'h06, 8'h01, 8'h0c, 8'h00, 8'h01, 8'hc1};
    logic        iq[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      fifo_en  <= (i == 5);
      auto_cts <= (i == 5);
      wr(OFF_IER, ie[i]);
      wb(1'b0, OFF_ISTAT, 8'h00, 4'h1);
      pulse(k[i]);
      repeat (3) @(posedge clk_i);
      `CHK("irq", iq[i], irq)
      rdchk(OFF_IID, id[i], "iid");
      wb(1'b0, OFF_ISTAT, 8'h00, 4'h1);
    end
    fifo_en  <= 1'b0;
    auto_cts <= 1'b0;
    wr(OFF_IER, 8'h05);
    peer.send(8'h55);
    pulse(0);
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    rdchk(OFF_IID, 8'h06, "iid");
    rdchk(OFF_ISTAT, 8'h05, "istat");
    rdchk(OFF_IID, 8'h01, "iid");
    rdchk(OFF_DATA, 8'h55, "rx_byte");
  endtask

  task automatic t_prog();
    // First pass without fifo mode: the programmable level must stay inert
    for (int m = 0; m < 2; m++) begin
      fifo_en <= (m == 1);
      wr(OFF_IER, 8'h82);
      peer.got.delete();
      for (int i = 0; i < 6; i++) wr(OFF_DATA, 8'hc0 + i[7:0]);
      wb(1'b0, OFF_ISTAT, 8'h00, 4'h1);
      peer.budget <= 2;
      wait_got(2);
      `CHK("irq", (m == 1), irq)
      rdchk(OFF_ISTAT, (m == 1) ? 8'h02 : 8'h00, "istat");
      wr(OFF_IER, 8'h02);
      peer.budget <= 1;
      wait_got(3);
      rdchk(OFF_ISTAT, 8'h00, "istat");
      peer.budget <= 3;
      wait_got(6);
      rdchk(OFF_ISTAT, 8'h02, "istat");
    end
    fifo_en <= 1'b0;
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, divisor_access_select, fifo_en, auto_cts} = 6'h00;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'h1;
    ev = 3'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_rx();
    t_tx();
    t_irq();
    t_prog();
    stop_test();
  end
endmodule
`default_nettype wire
